// >>> design/ibm_pkg.sv
// Constants and carrier types for the in-band management frame checker.
// Assumes a byte-wide receive stream from the switch and an Avalon-MM register master.
`default_nettype none
package ibm_pkg;
	// Register byte addresses
	localparam logic [11:0] ADDR_CTRL     = 12'h104;
	localparam logic [11:0] ADDR_STAT     = 12'h110;
	localparam logic [11:0] ADDR_MAC0     = 12'h140;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h180;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h184;
	localparam int          MAC_BYTES     = 6;

	// Control register fields
	localparam int CTRL_ON_BIT    = 31;
	localparam int CTRL_DACHK_BIT = 30;
	localparam int CTRL_RST_BIT   = 29;
	localparam int CTRL_QUEUE_LSB = 22;
	localparam int CTRL_PORT_LSB  = 16;
	localparam logic        DACHK_RST = 1'h1;
	localparam logic [1:0]  QUEUE_RST = 2'h1;
	localparam logic [2:0]  PORT_RST  = 3'h2;
	localparam logic [15:0] TAG_RST   = 16'h40FE;
	localparam logic [2:0]  PORT_LAST = 3'h2;

	// Status register fields
	localparam int ST_GOOD_BIT = 31;
	localparam int ST_TX_BIT   = 30;
	localparam int ST_EXEC_BIT = 29;
	localparam int ST_MIS_BIT  = 14;
	localparam int ST_FMT_BIT  = 13;
	localparam int ST_CODE_BIT = 12;
	localparam int ST_CMD_BIT  = 11;
	localparam int ST_OVER_BIT = 10;

	// Interrupt status and mask layout
	localparam int IRQ_W        = 4;
	localparam int IRQ_GOOD_BIT = 0;
	localparam int IRQ_TX_BIT   = 1;
	localparam int IRQ_EXEC_BIT = 2;
	localparam int IRQ_ERR_BIT  = 3;

	// Frame layout and checks
	localparam logic [9:0]  OFS_TAG_LO  = 10'h00D;
	localparam logic [9:0]  OFS_FMT_LO  = 10'h00F;
	localparam logic [9:0]  OFS_CODE_LO = 10'h011;
	localparam logic [9:0]  MAX_FRAME   = 10'h140;
	localparam logic [9:0]  CNT_TOP     = 10'h3FF;
	localparam logic [15:0] ACCESS_FMT  = 16'h9800;
	localparam logic [15:0] ACCESS_RD   = 16'h0001;
	localparam logic [15:0] ACCESS_WR   = 16'h0002;
	localparam logic [7:0]  CMD_END     = 8'h00;
	localparam logic [7:0]  CMD_LAST    = 8'h04;
	localparam logic [6:0]  IDX_TOP     = 7'h7F;

	typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_CMD, ST_SKIP} ibm_fsm_t;

	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic [1:0] port;
		logic [7:0] data;
	} ibm_rx_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [11:0] address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} ibm_avs_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] word;
		logic [6:0]  index;
	} ibm_cmd_t;

	typedef struct packed {
		logic       req;
		logic [1:0] queue;
		logic [2:0] port;
	} ibm_rsp_t;
endpackage
`default_nettype wire

// >>> design/ibm_frame_checker.sv
// In-band management frame checker: control/status registers, frame header and
// command checks, command hand-off and response request.
// Assumes the switch delivers each received frame as a byte stream with sof/eof,
// an external engine executes commands and reports cmdDone, and the
// transmit path reports rspSent once the response frame leaves.
`timescale 1ns/1ps
`default_nettype none
module ibm_frame_checker #(
	parameter logic [47:0] MAC_RESET = 48'h0010A1000000
) (
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	input  wire logic                  featureStrapPin,
	input  wire ibm_pkg::ibm_avs_req_t avsReq,
	output logic                       avsWaitrequest,
	output logic [31:0]                avsReaddata,
	input  wire ibm_pkg::ibm_rx_t      rx,
	output ibm_pkg::ibm_cmd_t          cmd,
	input  wire logic                  cmdDone,
	output ibm_pkg::ibm_rsp_t          rsp,
	input  wire logic                  rspSent,
	output logic                       irq
);
	typedef struct packed {
		ibm_pkg::ibm_fsm_t fsm;
		logic              on;
		logic              daChk;
		logic              mgmtRst;
		logic [1:0]        queue;
		logic [2:0]        port;
		logic [15:0]       tag;
		logic [47:0]       mac;
		logic              stGood;
		logic              stTx;
		logic              stExec;
		logic              stMis;
		logic              stFmt;
		logic              stCode;
		logic              stCmd;
		logic              stOver;
		logic [6:0]        errLoc;
		logic [3:0]        irqStat;
		logic [3:0]        irqMask;
		logic              irq;
		logic [9:0]        byteCnt;
		logic              daDiff;
		logic              inMgmt;
		logic [7:0]        lastByte;
		logic [23:0]       cmdAcc;
		logic [1:0]        cmdByte;
		logic [6:0]        cmdIdx;
		logic              cmdStop;
		logic              waitExec;
		logic [6:0]        pend;
		logic              ack;
		logic [31:0]       rdData;
		ibm_pkg::ibm_cmd_t cmd;
		ibm_pkg::ibm_rsp_t rsp;
	} ibm_regs_t;

	ibm_regs_t q;
	ibm_regs_t d;

	function automatic logic [31:0] beMerge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	function automatic logic [7:0] macByte(logic [47:0] m, logic [9:0] i);
		logic [7:0] r;
		r = 8'h00;
		for (int k = 0; k < ibm_pkg::MAC_BYTES; k++)
		begin
			if (i == 10'(k))
				r = m[8*(ibm_pkg::MAC_BYTES-1-k) +: 8];
		end
		return r;
	endfunction

	function automatic logic [31:0] ctrlWord(ibm_regs_t s);
		logic [31:0] r;
		r = 32'h00000000;
		r[ibm_pkg::CTRL_ON_BIT] = s.on;
		r[ibm_pkg::CTRL_DACHK_BIT] = s.daChk;
		r[ibm_pkg::CTRL_QUEUE_LSB +: 2] = s.queue;
		r[ibm_pkg::CTRL_PORT_LSB +: 3] = s.port;
		r[15:0] = s.tag;
		return r;
	endfunction

	logic        req;
	logic [31:0] statWord;
	logic [31:0] ctrlNew;
	logic [15:0] word16;
	logic [31:0] word32;
	logic [9:0]  cnt;
	logic        errEvt;

	assign req = avsReq.read | avsReq.write;
	// Exactly one wait state: readdata is registered before waitrequest drops
	assign avsWaitrequest = req & ~q.ack;
	assign avsReaddata = q.rdData;
	assign cmd = q.cmd;
	assign rsp = q.rsp;
	assign irq = q.irq;

	always_comb
	begin
		d = q;
		statWord = 32'h00000000;
		ctrlNew = 32'h00000000;
		word16 = {q.lastByte, rx.data};
		word32 = {q.cmdAcc, rx.data};
		cnt = q.byteCnt;
		errEvt = 1'b0;
		d.mgmtRst = 1'b0;
		d.ack = 1'b0;
		d.cmd.valid = 1'b0;
		d.rsp.req = 1'b0;

		statWord[ibm_pkg::ST_GOOD_BIT] = q.stGood;
		statWord[ibm_pkg::ST_TX_BIT] = q.stTx;
		statWord[ibm_pkg::ST_EXEC_BIT] = q.stExec;
		statWord[ibm_pkg::ST_MIS_BIT] = q.stMis;
		statWord[ibm_pkg::ST_FMT_BIT] = q.stFmt;
		statWord[ibm_pkg::ST_CODE_BIT] = q.stCode;
		statWord[ibm_pkg::ST_CMD_BIT] = q.stCmd;
		statWord[ibm_pkg::ST_OVER_BIT] = q.stOver;
		statWord[6:0] = q.errLoc;

		// Register bus: first cycle latches read data, second cycle commits
		if (req && !q.ack)
		begin
			d.ack = 1'b1;
			d.rdData = 32'h00000000;
			if (avsReq.address[11:2] == ibm_pkg::ADDR_CTRL[11:2])
				d.rdData = ctrlWord(q);
			else if (avsReq.address[11:2] == ibm_pkg::ADDR_STAT[11:2])
				d.rdData = statWord;
			else if (avsReq.address[11:2] == ibm_pkg::ADDR_IRQ_STAT[11:2])
				d.rdData = {28'h0000000, q.irqStat};
			else if (avsReq.address[11:2] == ibm_pkg::ADDR_IRQ_MASK[11:2])
				d.rdData = {28'h0000000, q.irqMask};
			for (int k = 0; k < ibm_pkg::MAC_BYTES; k++)
			begin
				if (avsReq.address[11:2] == ibm_pkg::ADDR_MAC0[11:2] + 10'(k))
					d.rdData = {24'h000000, macByte(q.mac, 10'(k))};
			end
		end
		if (req && q.ack && avsReq.write)
		begin
			if (avsReq.address[11:2] == ibm_pkg::ADDR_CTRL[11:2])
			begin
				ctrlNew = beMerge(ctrlWord(q), avsReq.writedata, avsReq.byteenable);
				d.on = ctrlNew[ibm_pkg::CTRL_ON_BIT];
				d.daChk = ctrlNew[ibm_pkg::CTRL_DACHK_BIT];
				d.mgmtRst = ctrlNew[ibm_pkg::CTRL_RST_BIT] & avsReq.byteenable[3];
				d.queue = ctrlNew[ibm_pkg::CTRL_QUEUE_LSB +: 2];
				d.port = ctrlNew[ibm_pkg::CTRL_PORT_LSB +: 3];
				d.tag = ctrlNew[15:0];
			end
			if (avsReq.address[11:2] == ibm_pkg::ADDR_IRQ_MASK[11:2] && avsReq.byteenable[0])
				d.irqMask = avsReq.writedata[3:0];
			for (int k = 0; k < ibm_pkg::MAC_BYTES; k++)
			begin
				if (avsReq.address[11:2] == ibm_pkg::ADDR_MAC0[11:2] + 10'(k)
					&& avsReq.byteenable[0])
					d.mac[8*(ibm_pkg::MAC_BYTES-1-k) +: 8] = avsReq.writedata[7:0];
			end
		end
		// Read clears; events below are applied afterwards so a set wins
		if (req && q.ack && avsReq.read && avsReq.address[11:2] == ibm_pkg::ADDR_IRQ_STAT[11:2])
			d.irqStat = 4'h0;

		// Pending command count from the execution engine
		if (cmdDone && q.pend != 7'h00)
			d.pend = q.pend - 7'h01;

		if (rx.valid)
		begin
			if (rx.sof)
			begin
				d.byteCnt = 10'h001;
				d.daDiff = (rx.data != macByte(q.mac, 10'h000));
				d.inMgmt = 1'b0;
				// Port codes 011-111 match no port, so traffic is never taken
				if (q.on && q.port <= ibm_pkg::PORT_LAST && {1'b0, rx.port} == q.port)
					d.fsm = ibm_pkg::ST_HDR;
				else
					d.fsm = ibm_pkg::ST_SKIP;
			end
			else if (q.fsm != ibm_pkg::ST_IDLE)
			begin
				cnt = q.byteCnt;
				if (q.byteCnt != ibm_pkg::CNT_TOP)
					d.byteCnt = q.byteCnt + 10'h001;
				d.lastByte = rx.data;
				unique case (q.fsm)
					ibm_pkg::ST_HDR:
					begin
						if (cnt < 10'(ibm_pkg::MAC_BYTES) && rx.data != macByte(q.mac, cnt))
							d.daDiff = 1'b1;
						if (cnt == ibm_pkg::OFS_TAG_LO)
						begin
							if (word16 != q.tag)
								d.fsm = ibm_pkg::ST_SKIP;
							else
							begin
								d.inMgmt = 1'b1;
								d.stTx = 1'b0;
								d.stExec = 1'b0;
								d.stMis = 1'b0;
								d.stFmt = 1'b0;
								d.stCode = 1'b0;
								d.stCmd = 1'b0;
								d.stOver = 1'b0;
								d.errLoc = 7'h00;
								d.waitExec = 1'b0;
								if (q.daChk && q.daDiff)
								begin
									d.stMis = 1'b1;
									errEvt = 1'b1;
									d.fsm = ibm_pkg::ST_SKIP;
								end
							end
						end
						if (cnt == ibm_pkg::OFS_FMT_LO && word16 != ibm_pkg::ACCESS_FMT)
						begin
							d.stFmt = 1'b1;
							errEvt = 1'b1;
						end
						if (cnt == ibm_pkg::OFS_CODE_LO)
						begin
							if (word16 != ibm_pkg::ACCESS_RD && word16 != ibm_pkg::ACCESS_WR)
							begin
								d.stCode = 1'b1;
								errEvt = 1'b1;
							end
							// Bad header: commands are still walked but never issued
							d.cmdStop = q.stFmt | d.stCode;
							d.cmdByte = 2'h0;
							d.cmdIdx = 7'h00;
							d.fsm = ibm_pkg::ST_CMD;
						end
					end
					ibm_pkg::ST_CMD:
					begin
						d.cmdAcc = word32[23:0];
						d.cmdByte = q.cmdByte + 2'h1;
						if (q.cmdByte == 2'h3)
						begin
							if (q.cmdIdx != ibm_pkg::IDX_TOP)
								d.cmdIdx = q.cmdIdx + 7'h01;
							if (!q.cmdStop)
							begin
								if (word32[31:24] == ibm_pkg::CMD_END)
									d.cmdStop = 1'b1;
								else if (word32[31:24] > ibm_pkg::CMD_LAST)
								begin
									d.stCmd = 1'b1;
									d.errLoc = q.cmdIdx;
									d.cmdStop = 1'b1;
									errEvt = 1'b1;
								end
								else
								begin
									d.cmd.valid = 1'b1;
									d.cmd.word = word32;
									d.cmd.index = q.cmdIdx;
									d.pend = d.pend + 7'h01;
								end
							end
						end
					end
					ibm_pkg::ST_SKIP:
					begin
					end
				endcase
				if (d.inMgmt && d.byteCnt > ibm_pkg::MAX_FRAME && !q.stOver)
				begin
					d.stOver = 1'b1;
					errEvt = 1'b1;
				end
			end
			if (rx.eof && d.fsm != ibm_pkg::ST_IDLE)
			begin
				if (d.inMgmt && !d.stMis)
				begin
					// Oversize frames get no response at all
					if (!d.stOver)
					begin
						d.rsp.req = 1'b1;
						d.rsp.queue = q.queue;
						d.rsp.port = q.port;
					end
					if (!(d.stFmt | d.stCode | d.stCmd | d.stOver))
					begin
						d.stGood = 1'b1;
						d.irqStat[ibm_pkg::IRQ_GOOD_BIT] = 1'b1;
						d.waitExec = 1'b1;
					end
				end
				d.inMgmt = 1'b0;
				d.fsm = ibm_pkg::ST_IDLE;
			end
		end

		// Done only when the frame has ended and every issued command reported back
		if (d.waitExec && d.pend == 7'h00)
		begin
			d.stExec = 1'b1;
			d.waitExec = 1'b0;
			d.irqStat[ibm_pkg::IRQ_EXEC_BIT] = 1'b1;
		end
		if (rspSent)
		begin
			d.stTx = 1'b1;
			d.irqStat[ibm_pkg::IRQ_TX_BIT] = 1'b1;
		end
		if (errEvt)
			d.irqStat[ibm_pkg::IRQ_ERR_BIT] = 1'b1;

		if (q.mgmtRst)
		begin
			d.fsm = ibm_pkg::ST_IDLE;
			d.stGood = 1'b0;
			d.stTx = 1'b0;
			d.stExec = 1'b0;
			d.stMis = 1'b0;
			d.stFmt = 1'b0;
			d.stCode = 1'b0;
			d.stCmd = 1'b0;
			d.stOver = 1'b0;
			d.errLoc = 7'h00;
			d.inMgmt = 1'b0;
			d.waitExec = 1'b0;
			d.pend = 7'h00;
			d.cmd.valid = 1'b0;
			d.rsp.req = 1'b0;
		end
		d.irq = |(d.irqStat & d.irqMask);

		if (!nrst)
		begin
			d = '0;
			d.fsm = ibm_pkg::ST_IDLE;
			d.on = featureStrapPin;
			d.daChk = ibm_pkg::DACHK_RST;
			d.queue = ibm_pkg::QUEUE_RST;
			d.port = ibm_pkg::PORT_RST;
			d.tag = ibm_pkg::TAG_RST;
			d.mac = MAC_RESET;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		q <= d;
	end
endmodule
`default_nettype wire

// >>> sim/ibm_frame_checker_monitor.sv
// Port checker for the management frame checker.
// Assumes one sys_clk domain and frames arriving as a byte stream.
`timescale 1ns/1ps
`default_nettype none
module ibm_frame_checker_monitor (
	input wire logic                  sys_clk,
	input wire logic                  nrst,
	input wire logic                  featureStrapPin,
	input wire ibm_pkg::ibm_avs_req_t avsReq,
	input wire logic                  avsWaitrequest,
	input wire logic [31:0]           avsReaddata,
	input wire ibm_pkg::ibm_rx_t      rx,
	input wire ibm_pkg::ibm_cmd_t     cmd,
	input wire logic                  cmdDone,
	input wire ibm_pkg::ibm_rsp_t     rsp,
	input wire logic                  rspSent,
	input wire logic                  irq
);
	logic [9:0] byteCnt;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Saturates so a runaway frame cannot wrap back under the limit
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			byteCnt <= 10'h000;
		else if (rx.valid)
			byteCnt <= rx.sof ? 10'h001 : byteCnt + {9'h000, byteCnt != 10'h3FF};
	end
	sequence s_rdack(logic [11:0] a);
		avsReq.read && !avsWaitrequest && avsReq.address[11:2] == a[11:2];
	endsequence
	sequence s_bigEnd;
		rx.valid && rx.eof && !rx.sof && byteCnt >= 10'h140;
	endsequence
	AST_ONE_WAIT: assert property ((avsReq.read || avsReq.write) && avsWaitrequest
		|=> !avsWaitrequest) else $error("bus answer late");
	AST_CTRL_RSVD: assert property (s_rdack(ibm_pkg::ADDR_CTRL) |->
		avsReaddata[29:24] == 6'h00 && avsReaddata[21:19] == 3'h0) else $error("control bits");
	AST_STAT_RSVD: assert property (s_rdack(ibm_pkg::ADDR_STAT) |->
		avsReaddata[28:15] == 14'h0000 && avsReaddata[9:7] == 3'h0) else $error("status bits");
	AST_MAC_BYTE: assert property (avsReq.read && !avsWaitrequest
		&& avsReq.address[11:6] == 6'h05 && avsReq.address[5:2] < 4'h6
		|-> avsReaddata[31:8] == 24'h000000) else $error("mac byte wide");
	AST_RSP_AFTER_EOF: assert property (rsp.req |-> $past(rx.valid && rx.eof)
		&& $past(rx.port) == rsp.port[1:0]) else $error("response without frame end");
	AST_OVERSIZE_QUIET: assert property (s_bigEnd |=> !rsp.req)
		else $error("response to oversize frame");
	AST_CMD_PULSE: assert property (cmd.valid |=> !cmd.valid [*3])
		else $error("command pulse too long");
	AST_CMD_CODE: assert property (cmd.valid |-> cmd.word[31:24] inside {[8'h01:8'h04]}
		&& $past(rx.valid)) else $error("bad command issued");
endmodule
bind ibm_frame_checker ibm_frame_checker_monitor i_mon (.sys_clk(sys_clk), .nrst(nrst),
	.featureStrapPin(featureStrapPin), .avsReq(avsReq), .avsWaitrequest(avsWaitrequest),
	.avsReaddata(avsReaddata), .rx(rx), .cmd(cmd), .cmdDone(cmdDone), .rsp(rsp),
	.rspSent(rspSent), .irq(irq));
`default_nettype wire

// >>> sim/ibm_host_model.sv
// Management host and switch far side: sends frames, answers commands and sends.
// Assumes the bench composes frame bytes in frm before calling send.
`timescale 1ns/1ps
`default_nettype none
module ibm_host_model (
	input wire logic              sys_clk,
	output ibm_pkg::ibm_rx_t      rx,
	input wire ibm_pkg::ibm_cmd_t cmd,
	output logic                  cmdDone,
	input wire ibm_pkg::ibm_rsp_t rsp,
	output logic                  rspSent
);
	logic [7:0] frm [340];
	logic [2:0] sentDly;
	int         slow;
	int         waitQ;
	initial
	begin
		rx = '0;
		cmdDone = 1'b0;
		rspSent = 1'b0;
		sentDly = 3'h0;
		slow = 0;
		waitQ = 0;
	end
	// Bytes go out as composed, tag, format and code included
	task automatic send(input int n, input logic [1:0] p);
		for (int i = 0; i < n; i++)
		begin
			@(posedge sys_clk);
			rx <= '{1'b1, i == 0, i == n - 1, p, frm[i]};
		end
		@(posedge sys_clk);
		// Released line shows the inverse, never a stale byte
		rx <= '{1'b0, 1'b0, 1'b0, p, ~frm[n - 1]};
	endtask
	always @(posedge sys_clk)
	begin
		sentDly <= {sentDly[1:0], rsp.req === 1'b1};
		rspSent <= sentDly[2];
		if (cmd.valid === 1'b1)
			waitQ <= slow;
		else if (waitQ > 0)
			waitQ <= waitQ - 1;
		cmdDone <= (cmd.valid === 1'b1 && slow == 0) || waitQ == 1;
	end
endmodule
`default_nettype wire

// >>> sim/ibm_frame_checker_test.sv
// Self-checking bench for the management frame checker.
// Assumes the host model as far side and a 250 MHz sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ibm_frame_checker_test;
	localparam logic [15:0] TG = 16'h40FE;
	localparam logic [15:0] FM = 16'h9800;
	typedef struct packed {
		logic [1:0]  p;
		logic        da;
		logic [15:0] t;
		logic [15:0] f;
		logic [15:0] a;
		logic [7:0]  c;
		logic [31:0] st;
		logic        r;
	} ibm_row_t;
	logic                  sys_clk = 1'b0;
	logic                  nrst = 1'b0;
	logic                  strap = 1'b1;
	ibm_pkg::ibm_avs_req_t req = '0;
	logic                  waitReq;
	logic                  irq;
	logic                  cmdDone;
	logic                  rspSent;
	logic [31:0]           rdata;
	logic [31:0]           q;
	logic [31:0]           lastCmd;
	logic [6:0]            lastIdx;
	logic [4:0]            rspQP;
	logic [7:0]            fb [340];
	ibm_pkg::ibm_rx_t      rx;
	ibm_pkg::ibm_cmd_t     cmd;
	ibm_pkg::ibm_rsp_t     rsp;
	int                    errors = 0;
	int                    checks_done = 0;
	int                    cyc = 0;
	int                    rspCnt = 0;
	// Bit 31 is not cleared by a new tagged frame, so rows carry it on
	ibm_row_t rows [10] = '{
		'{2'h2, 1'h1, TG, FM, 16'h0001, 8'h01, 32'hE0000000, 1'h1},
		'{2'h2, 1'h1, TG, FM, 16'h0002, 8'h04, 32'hE0000000, 1'h1},
		'{2'h2, 1'h1, TG, FM, 16'h0001, 8'h00, 32'hE0000000, 1'h1},
		'{2'h2, 1'h1, TG, 16'h9801, 16'h0001, 8'h01, 32'hC0002000, 1'h1},
		'{2'h2, 1'h1, TG, FM, 16'h0003, 8'h01, 32'hC0001000, 1'h1},
		'{2'h2, 1'h1, TG, FM, 16'h0000, 8'h01, 32'hC0001000, 1'h1},
		'{2'h2, 1'h1, TG, FM, 16'h0001, 8'h05, 32'hC0000800, 1'h1},
		'{2'h2, 1'h1, 16'h40FF, FM, 16'h0001, 8'h01, 32'hC0000800, 1'h0},
		'{2'h0, 1'h1, TG, FM, 16'h0001, 8'h01, 32'hC0000800, 1'h0},
		'{2'h2, 1'h0, TG, FM, 16'h0001, 8'h01, 32'h80004000, 1'h0}};
	ibm_frame_checker i_dut (.sys_clk(sys_clk), .nrst(nrst), .featureStrapPin(strap),
		.avsReq(req), .avsWaitrequest(waitReq), .avsReaddata(rdata), .rx(rx), .cmd(cmd),
		.cmdDone(cmdDone), .rsp(rsp), .rspSent(rspSent), .irq(irq));
	ibm_host_model i_host (.sys_clk(sys_clk), .rx(rx), .cmd(cmd), .cmdDone(cmdDone),
		.rsp(rsp), .rspSent(rspSent));
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic close_out;
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{!w, w, a, d, 4'hF};
		do @(posedge sys_clk); while (waitReq !== 1'b0);
		q = rdata;
		req <= '0;
	endtask
	// Bench fills in tag, format and access code, then copies the frame to the host
	task automatic mk(input logic da, input logic [15:0] t, f, a, input logic [7:0] c);
		for (int i = 0; i < 340; i++)
			fb[i] = 8'h00;
		fb[0] = da ? 8'h00 : 8'h5A;
		fb[1] = 8'h10;
		fb[2] = 8'hA1;
		{fb[12], fb[13], fb[14], fb[15], fb[16], fb[17]} = {t, f, a};
		{fb[18], fb[19], fb[20], fb[21]} = {c, 24'h123456};
		i_host.frm = fb;
	endtask
	task automatic go(input int n, input logic [1:0] p);
		rspCnt = 0;
		i_host.send(n, p);
		repeat (8) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (rsp.req === 1'b1)
		begin
			rspCnt++;
			rspQP = {rsp.queue, rsp.port};
		end
		if (cmd.valid === 1'b1)
		begin
			lastCmd = cmd.word;
			lastIdx = cmd.index;
		end
		if (cyc == 20000)
		begin
			errors++;
			close_out();
		end
	end
	initial
	begin
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		bus(0, ibm_pkg::ADDR_CTRL, 0);
		chk(32'hC04240FE, q);
		bus(1, ibm_pkg::ADDR_STAT, 32'hFFFFFFFF);
		bus(0, ibm_pkg::ADDR_STAT, 0);
		chk(32'h00000000, q);
		bus(0, ibm_pkg::ADDR_MAC0 + 12'h004, 0);
		chk(32'h00000010, q);
		bus(0, 12'h200, 0);
		chk(32'h00000000, q);
		for (int k = 0; k < 10; k++)
		begin
			mk(rows[k].da, rows[k].t, rows[k].f, rows[k].a, rows[k].c);
			go(22, rows[k].p);
			bus(0, ibm_pkg::ADDR_STAT, 0);
			chk(rows[k].st, q);
			chk({31'h0, rows[k].r}, rspCnt);
			if (rows[k].st[29] && rows[k].c != 8'h00 && rows[k].r)
				chk({rows[k].c, 24'h123456}, lastCmd);
		end
		chk({27'h0, 5'h0A}, {27'h0, rspQP});
		for (int n = 320; n < 322; n++)
		begin
			mk(1, TG, FM, 16'h0001, 8'h01);
			go(n, 2);
			bus(0, ibm_pkg::ADDR_STAT, 0);
			chk(n == 320 ? 32'hE0000000 : 32'h80000400, q);
			chk(n == 320, rspCnt);
		end
		mk(1, TG, FM, 16'h0001, 8'h01);
		fork
			go(22, 2);
			begin
				repeat (8) @(posedge sys_clk);
				bus(1, ibm_pkg::ADDR_CTRL, 32'hE04240FE);
			end
		join
		chk(0, rspCnt);
		bus(0, ibm_pkg::ADDR_STAT, 0);
		chk(32'h00000000, q);
		bus(0, ibm_pkg::ADDR_CTRL, 0);
		chk(32'hC04240FE, q);
		mk(1, TG, FM, 16'h0001, 8'h01);
		// Second command still valid, third one bad: location must point past both
		i_host.frm[22] = 8'h02;
		i_host.frm[26] = 8'h07;
		go(30, 2);
		bus(0, ibm_pkg::ADDR_STAT, 0);
		chk(32'h40000802, q);
		chk(32'h02000000, lastCmd);
		chk(32'h00000001, {25'h0, lastIdx});
		bus(1, ibm_pkg::ADDR_CTRL, 32'h80811234);
		i_host.slow = 3;
		mk(0, 16'h1234, FM, 16'h0002, 8'h01);
		go(22, 1);
		bus(0, ibm_pkg::ADDR_STAT, 0);
		chk(32'hE0000000, q);
		chk({27'h0, 5'h11}, {27'h0, rspQP});
		chk(0, irq);
		bus(0, ibm_pkg::ADDR_IRQ_STAT, 0);
		chk(32'h0000000F, q);
		bus(1, ibm_pkg::ADDR_IRQ_MASK, 32'h00000001);
		go(22, 1);
		chk(1, irq);
		bus(0, ibm_pkg::ADDR_IRQ_STAT, 0);
		chk(32'h00000007, q);
		repeat (2) @(posedge sys_clk);
		chk(0, irq);
		// Reserved port code must match no ingress port
		bus(1, ibm_pkg::ADDR_CTRL, 32'hC04340FE);
		mk(1, TG, FM, 16'h0001, 8'h01);
		go(22, 3);
		chk(0, rspCnt);
		bus(0, ibm_pkg::ADDR_STAT, 0);
		chk(32'hE0000000, q);
		strap <= 1'b0;
		nrst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		bus(0, ibm_pkg::ADDR_CTRL, 0);
		chk(32'h404240FE, q);
		mk(1, TG, FM, 16'h0001, 8'h01);
		go(22, 2);
		chk(0, rspCnt);
		close_out();
	end
endmodule
`default_nettype wire
